// File: include/eip_pkg.sv
// constants and types for the external interrupt pin logic
// assumes a single core clock; interrupt pins pass a two-stage synchroniser
package eip_pkg;

  // ----------------------------------------------------------------
  // widths and source numbering
  // ----------------------------------------------------------------
  localparam int unsigned ID_W     = 4;
  localparam int unsigned NSRC     = 16;
  localparam int unsigned NEXT     = 4;
  localparam logic [3:0]  ID_NMI   = 4'h1;
  localparam logic [3:0]  ID_EXT4  = 4'h4;
  localparam logic [3:0]  ID_NONE  = 4'h0;
  localparam logic [15:0] PEND_RST = 16'h0000;

  // service sequence states
  typedef enum logic [1:0] {
    EIP_IDLE,
    EIP_ACK
  } eip_state_e;

endpackage

// File: rtl/eip_edge.sv
// rising-edge detector with two-stage synchroniser
// assumes pin is asynchronous to clk or not; sync is harmless either way
module eip_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // pin and event
  input  wire logic pin,
  output logic      rise
);

  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;

  // ----------------------------------------------------------------
  // synchroniser and history
  // ----------------------------------------------------------------
  always_comb begin
    s1_d = pin;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // only stages two and three feed the comparator; stage one stays private
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // a level held high gives a single pulse
  assign rise = s2_q & ~s3_q;

  a_edge_single: assert property (@(posedge clk) disable iff (reset)
    rise |=> !rise)
    else $error("edge pulse lasted more than one cycle");

  // a pulse must trace back to the pin two samples earlier
  a_rise_from_pin: assert property (@(posedge clk) disable iff (reset)
    rise |-> $past(pin, 2))
    else $error("edge pulse without a matching pin level");

endmodule

// File: rtl/eip_top.sv
// pin-level interrupt logic: edge capture, pending, acknowledge, id
// assumes core raises service_req when it takes the chosen interrupt
module eip_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // pins
  input  wire logic        nmi_pin,
  input  wire logic        ext_irq_line_4,
  input  wire logic        ext_irq_line_5,
  input  wire logic        ext_irq_line_6,
  input  wire logic        ext_irq_line_7,
  // internal sources, bit n is service table position n
  input  wire logic [15:0] int_irq_pulse,
  // core service handshake
  input  wire logic        service_req,
  // pending view and acknowledge
  output logic [15:0]      pending_out,
  output logic             irq_acknowledge_out,
  output logic [3:0]       serviced_irq_id
);

  logic [eip_pkg::NEXT-1:0] ext_pins;
  logic [eip_pkg::NEXT-1:0] ext_rise;
  logic                     nmi_rise;
  logic [15:0]              edge_vec;

  // pending flags, service state and registered outputs
  logic [15:0]              pend_q;
  logic [15:0]              pend_d;
  eip_pkg::eip_state_e      st_q;
  eip_pkg::eip_state_e      st_d;
  logic                     ack_q;
  logic                     ack_d;
  logic [3:0]               id_q;
  logic [3:0]               id_d;

  // shared priority choice, so the state logic and the checks agree
  logic [3:0]               sel_id;
  logic                     any_pend;

  // pins gathered so line n sits at bit n-4
  assign ext_pins = {ext_irq_line_7, ext_irq_line_6, ext_irq_line_5, ext_irq_line_4};

  // ----------------------------------------------------------------
  // edge detectors
  // ----------------------------------------------------------------
  eip_edge u_nmi (
    .clk   (clk),
    .reset (reset),
    .pin   (nmi_pin),
    .rise  (nmi_rise)
  );

  genvar gi;
  generate
    for (gi = 0; gi < eip_pkg::NEXT; gi++) begin : g_ext
      eip_edge u_ext (
        .clk   (clk),
        .reset (reset),
        .pin   (ext_pins[gi]),
        .rise  (ext_rise[gi])
      );
    end
  endgenerate

  // pin events land at their table positions
  always_comb begin
    edge_vec = int_irq_pulse;
    edge_vec[eip_pkg::ID_NMI] = edge_vec[eip_pkg::ID_NMI] | nmi_rise;
    for (int i = 0; i < eip_pkg::NEXT; i++) begin
      edge_vec[eip_pkg::ID_EXT4 + 4'(i)] = edge_vec[eip_pkg::ID_EXT4 + 4'(i)] | ext_rise[i];
    end
  end

  // lowest nonzero table position wins, matching service priority
  function automatic logic [3:0] pick(input logic [15:0] v);
    logic [3:0] r;
    r = eip_pkg::ID_NONE;
    for (int i = eip_pkg::NSRC - 1; i >= 1; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // any source at a serviceable position; bit zero never wins a service
  function automatic logic has_request(input logic [15:0] v);
    return pick(v) != eip_pkg::ID_NONE;
  endfunction

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // one priority pick feeds both the state logic and the checks
  always_comb begin
    sel_id   = pick(pend_q);
    any_pend = has_request(pend_q);
  end

  // ----------------------------------------------------------------
  // pending, service and acknowledge
  // ----------------------------------------------------------------
  // next pending, state and outputs; a request during ack is ignored, only idle takes one
  always_comb begin
    pend_d = pend_q | edge_vec;
    st_d   = st_q;
    ack_d  = 1'b0;
    id_d   = id_q;
    unique case (st_q)
      eip_pkg::EIP_IDLE: begin
        if (service_req && any_pend) begin
          id_d   = sel_id;
          ack_d  = 1'b1;
          // a new edge on the same source survives the clear, else it is lost
          pend_d[sel_id] = edge_vec[sel_id];
          st_d   = eip_pkg::EIP_ACK;
        end
      end
      eip_pkg::EIP_ACK: begin
        st_d = eip_pkg::EIP_IDLE; // one-cycle acknowledge
      end
    endcase
  end

  // registers only; each top output is one of these flops
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_q <= eip_pkg::PEND_RST;
      st_q   <= eip_pkg::EIP_IDLE;
      ack_q  <= 1'b0;
      id_q   <= eip_pkg::ID_NONE;
    end else begin
      pend_q <= pend_d;
      st_q   <= st_d;
      ack_q  <= ack_d;
      id_q   <= id_d;
    end
  end

  // outputs come straight from the flops
  assign pending_out         = pend_q;
  assign irq_acknowledge_out = ack_q;
  assign serviced_irq_id     = id_q;

  // ----------------------------------------------------------------
  // checks on acknowledge and id
  // ----------------------------------------------------------------
  a_ack_has_id: assert property (@(posedge clk) disable iff (reset)
    irq_acknowledge_out |-> serviced_irq_id != eip_pkg::ID_NONE)
    else $error("acknowledge without a valid id");

  a_ack_follows_req: assert property (@(posedge clk) disable iff (reset)
    (st_q == eip_pkg::EIP_IDLE && service_req && any_pend)
      |=> irq_acknowledge_out && serviced_irq_id == pick($past(pend_q)))
    else $error("service did not acknowledge the chosen source");

  a_id_stable_ack: assert property (@(posedge clk) disable iff (reset)
    irq_acknowledge_out |=> $stable(serviced_irq_id))
    else $error("id changed right after acknowledge");

  a_ack_one_cycle: assert property (@(posedge clk) disable iff (reset)
    irq_acknowledge_out |=> !irq_acknowledge_out)
    else $error("acknowledge lasted more than one cycle");

  a_ack_needs_req: assert property (@(posedge clk) disable iff (reset)
    irq_acknowledge_out |-> $past(service_req) && $past(st_q) == eip_pkg::EIP_IDLE)
    else $error("acknowledge without an accepted service request");

  a_no_ack_empty: assert property (@(posedge clk) disable iff (reset)
    (st_q == eip_pkg::EIP_IDLE && !any_pend) |=> !irq_acknowledge_out)
    else $error("acknowledge with nothing pending");

  // the id must not move between services, or the far side reads a stale source
  a_id_holds_idle: assert property (@(posedge clk) disable iff (reset)
    (!reset && !irq_acknowledge_out
      && !(st_q == eip_pkg::EIP_IDLE && service_req && any_pend))
      |=> $stable(serviced_irq_id))
    else $error("id changed without a service");

  a_reset_quiet: assert property (@(posedge clk)
    reset |=> !irq_acknowledge_out && pending_out == eip_pkg::PEND_RST
      && serviced_irq_id == eip_pkg::ID_NONE)
    else $error("reset left state behind");

  // ----------------------------------------------------------------
  // checks on pending flags and edges
  // ----------------------------------------------------------------
  a_nmi_position: assert property (@(posedge clk) disable iff (reset)
    nmi_rise |=> pending_out[eip_pkg::ID_NMI])
    else $error("nmi edge not pending at its position");

  a_served_cleared: assert property (@(posedge clk) disable iff (reset)
    (st_q == eip_pkg::EIP_IDLE && service_req && any_pend && !edge_vec[sel_id])
      |=> !pending_out[$past(sel_id)])
    else $error("served source still pending");

  a_set_wins: assert property (@(posedge clk) disable iff (reset)
    (st_q == eip_pkg::EIP_IDLE && service_req && any_pend && edge_vec[sel_id])
      |=> pending_out[$past(sel_id)])
    else $error("edge lost while its source was served");

  // a pin already high across reset may give one pulse, so reset is excluded
  a_level_no_rearm: assert property (@(posedge clk) disable iff (reset)
    (!reset && ext_irq_line_4) [*4] |-> !ext_rise[0])
    else $error("held level raised a request");

  a_nmi_no_rearm: assert property (@(posedge clk) disable iff (reset)
    (!reset && nmi_pin) [*4] |-> !nmi_rise)
    else $error("held nmi level raised a request");

  // every external line gets the same level and position checks
  genvar gc;
  generate
    for (gc = 0; gc < eip_pkg::NEXT; gc++) begin : g_ext_chk
      a_ext_no_rearm: assert property (@(posedge clk) disable iff (reset)
        (!reset && ext_pins[gc]) [*4] |-> !ext_rise[gc])
        else $error("held external level raised a request");

      a_ext_position: assert property (@(posedge clk) disable iff (reset)
        ext_rise[gc] |=> pending_out[eip_pkg::ID_EXT4 + 4'(gc)])
        else $error("external edge not pending at its position");
    end
  endgenerate

endmodule

// File: verif/eip_src_model.sv
// model of the external parts that raise the interrupt pins
// assumes raise/drop come from the bench just after a clk edge
module eip_src_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // bench commands, bit 0 nonmaskable, bits 4:1 lines 4..7
  input  wire logic [4:0] raise,
  input  wire logic [4:0] drop,
  // pins
  output logic [4:0]      pins_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // level stays high until dropped, so only the edge may count
  always_ff @(posedge clk) begin
    pins_q <= reset ? 5'h00 : (pins_q | raise) & ~drop;
  end
endmodule

// File: verif/external_interrupt_pin_logic_tb_top.sv
// self-checking bench for the pin-level interrupt logic
// assumes one core clock and the service handshake of eip_top
module external_interrupt_pin_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, sreq = 1'b0;
  logic [4:0] raise = 5'h00, drop = 5'h00, pins;
  logic [15:0] intp = 16'h0000, pend, m;
  logic ack;
  logic [3:0] id;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  always #2.5 clk = ~clk;
  eip_src_model src (.clk(clk), .reset(reset), .raise(raise), .drop(drop), .pins_q(pins));
  eip_top uut (.clk(clk), .reset(reset), .nmi_pin(pins[0]), .ext_irq_line_4(pins[1]),
    .ext_irq_line_5(pins[2]), .ext_irq_line_6(pins[3]), .ext_irq_line_7(pins[4]),
    .int_irq_pulse(intp), .service_req(sreq), .pending_out(pend),
    .irq_acknowledge_out(ack), .serviced_irq_id(id));
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [3:0] lowest(input logic [15:0] v);
    for (int i = 1; i < 16; i++) if (v[i]) return 4'(i);
    return 4'h0;
  endfunction
  // one service request, then ack for exactly one cycle
  task svc(input logic [3:0] e);
    @(posedge clk) sreq <= 1'b1;
    @(posedge clk) sreq <= 1'b0;
    // ack stands only from the taking edge to the next one
    #1 chk("ack", 16'h0001, {15'h0000, ack});
    chk("id", {12'h000, e}, {12'h000, id});
    @(posedge clk);
    #1;
    chk("ack_end", 16'h0000, {15'h0000, ack});
    chk("id_hold", {12'h000, e}, {12'h000, id});
  endtask
  task final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h3fd9));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    // nothing pending: request must be ignored
    @(posedge clk) sreq <= 1'b1;
    @(posedge clk) sreq <= 1'b0;
    #1 chk("no_ack", 16'h0000, {15'h0000, ack});
    repeat (3) @(posedge clk);
    // each pin: edge makes one request, held level none more
    for (int k = 0; k < 5; k++) begin
      @(posedge clk) raise <= 5'(1 << k);
      @(posedge clk) raise <= 5'h00;
      repeat (5) @(posedge clk);
      #1 chk("pin_pend", 16'(1 << (k == 0 ? 1 : k + 3)), pend);
      svc(k == 0 ? 4'h1 : 4'(k + 3));
      repeat (6) @(posedge clk);
      #1 chk("no_repeat", 16'h0000, pend);
      @(posedge clk) drop <= 5'(1 << k);
      @(posedge clk) drop <= 5'h00;
    end
    // random internal sources, drained lowest index first
    repeat (20) begin
      m = 16'($urandom) & 16'hFFFE;
      if (m == 16'h0000) m = 16'h8000;
      @(posedge clk) intp <= m;
      @(posedge clk) intp <= 16'h0000;
      repeat (2) @(posedge clk);
      #1 chk("int_pend", m, pend);
      while (m != 16'h0000) begin
        svc(lowest(m));
        m[lowest(m)] = 1'b0;
      end
      #1 chk("drained", 16'h0000, pend);
    end
    // mid-run reset with a source pending: all outputs back to zero
    @(posedge clk) intp <= 16'h0010;
    @(posedge clk) intp <= 16'h0000;
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    #1 chk("rst_pend", 16'h0000, pend);
    chk("rst_id", 16'h0000, {12'h000, id});
    chk("rst_ack", 16'h0000, {15'h0000, ack});
    // corner: new edge on the source being served, request held through ack
    @(posedge clk) intp <= 16'h0108;
    @(posedge clk) intp <= 16'h0000;
    @(posedge clk);
    sreq <= 1'b1;
    intp <= 16'h0008;
    @(posedge clk) intp <= 16'h0000;
    #1 chk("set_ack", 16'h0001, {15'h0000, ack});
    chk("set_id", 16'h0003, {12'h000, id});
    chk("set_wins", 16'h0108, pend);
    @(posedge clk) sreq <= 1'b0;
    #1 chk("busy_ack", 16'h0000, {15'h0000, ack});
    chk("busy_pend", 16'h0108, pend);
    svc(4'h3);
    svc(4'h8);
    #1 chk("corner_drained", 16'h0000, pend);
    final_report;
  end
endmodule
